// ==== rtl/tcr_config_regs.sv ====
// Notes on behaviour
// - cal type: low nibble first, high second
// - unsupported variant reads cal type as zero
// - filter bit0 switches adaptive pressure filter
// - filter bit1 switches temperature low-pass filter
// - filter bits2-4 give oversampling exponent plus eight
// - filter bits5-6 give averaging 1,2,4,8
// - aout bit0 current, bit1 voltage
// - aout bit4 selects first pressure else calculated
// - only aout bit4 is writable
// - node address read/write, resets to one
// - two read-only firmware version words
// - conductivity power on 0x01, off 0x00
// - exception 4 during 3 s power-up
// - conductivity range codes 1..4, default 4
// - temp compensation codes 1..3, default 1
// - slow timeout register times 100us, default 35
// - fast timeout register times 100us, default 18
// - 16-byte serial, writable on one variant
// - adaptive digital only; low-pass both outputs
// - transparent address 250 always answered
`timescale 1ns/1ps
module tcr_config_regs #(
  parameter int POWERUP_CYC = tcr_pkg::CON_POWERUP_CYC,
  parameter logic HAS_CAL_TYPE = 1'b1,
  parameter logic SERIAL_WRITABLE = 1'b1,
  parameter logic [15:0] FW_CLASS_GROUP = 16'h1234, // Arbitrary value
  parameter logic [15:0] FW_YEAR_WEEK = 16'h5678 // Arbitrary value
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire tcr_pkg::tcr_req_type i_req,
  input wire logic [7:0] i_frame_addr,
  input wire logic i_fast_baud,
  input wire logic [3:0] i_first_sensor_type,
  input wire logic [3:0] i_second_sensor_type,
  input wire logic [15:0] i_device_status,
  input wire logic [1:0] i_aout_type,
  output tcr_pkg::tcr_rsp_type o_rsp,
  output logic o_addr_match,
  output tcr_pkg::tcr_ctrl_type o_ctrl,
  output logic o_aout_lowpass,
  output logic [15:0] o_ift_units,
  output logic [31:0] o_ift_cycles,
  output logic o_sps_invalid,
  output logic [15:0] o_sps_code
);
  import tcr_pkg::*;

  logic [15:0] filter_reg;
  logic aout_src_reg;
  logic [15:0] node_addr_reg;
  logic con_power_reg;
  logic [15:0] con_range_reg;
  logic [15:0] con_tcomp_reg;
  logic [15:0] ift_slow_reg;
  logic [15:0] ift_fast_reg;
  logic [15:0] sps_reg;
  logic [15:0] serial_reg [0:7];
  logic [31:0] pwr_cnt_reg;
  logic busy;
  logic wr;
  logic in_serial;
  logic [2:0] ser_idx;
  logic [15:0] rdata_next;
  logic [7:0] exc_next;
  tcr_rsp_type rsp_reg;
  logic wr_filter;
  logic wr_aout;
  logic wr_node;
  logic wr_power;
  logic wr_range;
  logic wr_tcomp;
  logic wr_ift_slow;
  logic wr_ift_fast;
  logic wr_sps;
  logic wr_serial;
  logic range_ok;
  logic tcomp_ok;
  logic [26:0] pins_meta_reg;
  logic [26:0] pins_sync_reg;
  logic fast_baud_sync;
  logic [3:0] first_type_sync;
  logic [3:0] second_type_sync;
  logic [15:0] status_sync;
  logic [1:0] aout_type_sync;

  assign busy = (pwr_cnt_reg != 32'h0000_0000);
  assign wr = i_req.valid && i_req.write && !busy;
  assign in_serial = (i_req.addr >= ADDR_SERIAL_BASE) &&
                     (i_req.addr <= ADDR_SERIAL_LAST);
  assign ser_idx = i_req.addr[2:0];
  assign range_ok = (i_req.wdata >= CON_RANGE_MIN) &&
                    (i_req.wdata <= CON_RANGE_MAX);
  assign tcomp_ok = (i_req.wdata >= CON_TCOMP_MIN) &&
                    (i_req.wdata <= CON_TCOMP_MAX);

  // ==========================================================
  // Pin synchronisers
  // Level pins from the sensor front end are not on this clock;
  // a word may mix old and new bits for one cycle, harmless for
  // slow status levels
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pins_meta_reg <= '0;
    end else begin
      pins_meta_reg <= {i_fast_baud, i_first_sensor_type,
                        i_second_sensor_type, i_device_status,
                        i_aout_type};
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pins_sync_reg <= '0;
    end else begin
      pins_sync_reg <= pins_meta_reg;
    end
  end

  assign {fast_baud_sync, first_type_sync, second_type_sync,
          status_sync, aout_type_sync} = pins_sync_reg;

  // ==========================================================
  // Write strobes
  // One decoder feeds every register, so a refused or unmapped
  // write can never reach any register
  always_comb begin
    wr_filter = 1'b0;
    wr_aout = 1'b0;
    wr_node = 1'b0;
    wr_power = 1'b0;
    wr_range = 1'b0;
    wr_tcomp = 1'b0;
    wr_ift_slow = 1'b0;
    wr_ift_fast = 1'b0;
    wr_sps = 1'b0;
    wr_serial = 1'b0;
    if (wr) begin
      if (i_req.addr == ADDR_FILTER_CTRL) begin
        wr_filter = 1'b1;
      end else if (i_req.addr == ADDR_AOUT_CTRL) begin
        wr_aout = 1'b1;
      end else if (i_req.addr == ADDR_NODE_ADDR) begin
        wr_node = 1'b1;
      end else if (i_req.addr == ADDR_CON_POWER) begin
        wr_power = 1'b1;
      end else if (i_req.addr == ADDR_CON_RANGE) begin
        wr_range = 1'b1;
      end else if (i_req.addr == ADDR_CON_TCOMP) begin
        wr_tcomp = 1'b1;
      end else if (i_req.addr == ADDR_IFT_SLOW) begin
        wr_ift_slow = 1'b1;
      end else if (i_req.addr == ADDR_IFT_FAST) begin
        wr_ift_fast = 1'b1;
      end else if (i_req.addr == ADDR_SPS) begin
        wr_sps = 1'b1;
      end else if (in_serial) begin
        wr_serial = SERIAL_WRITABLE;
      end
    end
  end

  // ==========================================================
  // Address match
  assign o_addr_match = (i_frame_addr == node_addr_reg[7:0]) ||
                        (i_frame_addr == TRANSPARENT_ADDR);

  // ==========================================================
  // Configuration registers
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      filter_reg <= RST_ZERO;
    end else if (wr_filter) begin
      filter_reg <= i_req.wdata & FC_WR_MASK;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      aout_src_reg <= 1'b0;
    end else if (wr_aout) begin
      aout_src_reg <= i_req.wdata[AO_SRC_BIT];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      node_addr_reg <= RST_NODE_ADDR;
    end else if (wr_node) begin
      node_addr_reg <= i_req.wdata;
    end
  end

  // Out-of-range codes are dropped so the sensor never sees them
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      con_range_reg <= RST_CON_RANGE;
    end else if (wr_range && range_ok) begin
      con_range_reg <= i_req.wdata;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      con_tcomp_reg <= RST_CON_TCOMP;
    end else if (wr_tcomp && tcomp_ok) begin
      con_tcomp_reg <= i_req.wdata;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ift_slow_reg <= RST_IFT_SLOW;
    end else if (wr_ift_slow) begin
      ift_slow_reg <= i_req.wdata;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ift_fast_reg <= RST_IFT_FAST;
    end else if (wr_ift_fast) begin
      ift_fast_reg <= i_req.wdata;
    end
  end

  // Any code is stored; validity is only flagged
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sps_reg <= RST_SPS;
    end else if (wr_sps) begin
      sps_reg <= i_req.wdata;
    end
  end

  // ==========================================================
  // Serial number store
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int k = 0; k < 8; k++) begin
        serial_reg[k] <= RST_ZERO;
      end
    end else if (wr_serial) begin
      serial_reg[ser_idx] <= i_req.wdata;
    end
  end

  // ==========================================================
  // Conductivity power and power-up hold-off
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      con_power_reg <= 1'b0;
    end else if (wr_power) begin
      if (i_req.wdata == CON_POWER_ON) begin
        con_power_reg <= 1'b1;
      end else if (i_req.wdata == RST_ZERO) begin
        con_power_reg <= 1'b0;
      end
    end
  end

  // Counter restarts only on an off-to-on change so a repeated
  // power-on write does not extend the hold-off
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pwr_cnt_reg <= 32'h0000_0000;
    end else if (wr_power && i_req.wdata == CON_POWER_ON &&
                 !con_power_reg) begin
      pwr_cnt_reg <= 32'(POWERUP_CYC);
    end else if (!con_power_reg) begin
      pwr_cnt_reg <= 32'h0000_0000;
    end else if (busy) begin
      pwr_cnt_reg <= pwr_cnt_reg - 32'h0000_0001;
    end
  end

  // ==========================================================
  // Read mux and answer
  always_comb begin
    rdata_next = RST_ZERO;
    exc_next = EXC_NONE;
    if (busy) begin
      exc_next = EXC_BUSY;
    end else if (i_req.addr == ADDR_SENSOR_CAL) begin
      if (HAS_CAL_TYPE) begin
        rdata_next = {8'h00, second_type_sync,
                      first_type_sync};
      end else begin
        rdata_next = RST_ZERO;
      end
    end else if (i_req.addr == ADDR_FILTER_CTRL) begin
      rdata_next = filter_reg;
    end else if (i_req.addr == ADDR_AOUT_CTRL) begin
      rdata_next = RST_ZERO;
      rdata_next[AO_CURRENT_BIT] = aout_type_sync[0];
      rdata_next[AO_VOLTAGE_BIT] = aout_type_sync[1];
      rdata_next[AO_SRC_BIT] = aout_src_reg;
    end else if (i_req.addr == ADDR_DEV_STATUS) begin
      rdata_next = status_sync;
    end else if (i_req.addr == ADDR_NODE_ADDR) begin
      rdata_next = node_addr_reg;
    end else if (i_req.addr == ADDR_FW_CLASS) begin
      rdata_next = FW_CLASS_GROUP;
    end else if (i_req.addr == ADDR_FW_YEAR) begin
      rdata_next = FW_YEAR_WEEK;
    end else if (i_req.addr == ADDR_CON_POWER) begin
      rdata_next = {15'h0000, con_power_reg};
    end else if (i_req.addr == ADDR_CON_RANGE) begin
      rdata_next = con_range_reg;
    end else if (i_req.addr == ADDR_CON_TCOMP) begin
      rdata_next = con_tcomp_reg;
    end else if (i_req.addr == ADDR_IFT_SLOW) begin
      rdata_next = ift_slow_reg;
    end else if (i_req.addr == ADDR_IFT_FAST) begin
      rdata_next = ift_fast_reg;
    end else if (i_req.addr == ADDR_SPS) begin
      rdata_next = sps_reg;
    end else if (in_serial) begin
      rdata_next = serial_reg[ser_idx];
    end else begin
      exc_next = EXC_ILLEGAL_ADDR;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rsp_reg <= '0;
    end else begin
      rsp_reg.valid <= i_req.valid;
      rsp_reg.exc <= exc_next;
      rsp_reg.rdata <= rdata_next;
    end
  end

  assign o_rsp = rsp_reg;

  // ==========================================================
  // Control outputs
  always_comb begin
    o_ctrl.adaptive_en = filter_reg[FC_ADAPT_BIT];
    o_ctrl.lowpass_en = filter_reg[FC_LPF_BIT];
    o_ctrl.osr_exp = OSR_BASE_EXP +
                     {1'b0, filter_reg[FC_OSR_LSB +: 3]};
    o_ctrl.avg_count = 4'(4'h1 << filter_reg[FC_AVG_LSB +: 2]);
    o_ctrl.aout_src_first = aout_src_reg;
    o_ctrl.con_powered = con_power_reg;
    o_ctrl.con_ready = con_power_reg && !busy;
  end

  // Adaptive filter never reaches the analogue path
  assign o_aout_lowpass = filter_reg[FC_LPF_BIT];
  assign o_ift_units = fast_baud_sync ? ift_fast_reg : ift_slow_reg;
  assign o_ift_cycles = 32'(o_ift_units) * 32'(IFT_UNIT_CYC);
  assign o_sps_code = sps_reg;
  assign o_sps_invalid = (sps_reg < SPS_MIN) || (sps_reg > SPS_MAX);
endmodule

// ==== rtl/tcr_pkg.sv ====
package tcr_pkg;
  // ==========================================================
  // Register addresses (holding register numbers)
  localparam logic [15:0] ADDR_SENSOR_CAL = 16'h0209;
  localparam logic [15:0] ADDR_FILTER_CTRL = 16'h020a;
  localparam logic [15:0] ADDR_AOUT_CTRL = 16'h020b;
  localparam logic [15:0] ADDR_DEV_STATUS = 16'h020c;
  localparam logic [15:0] ADDR_NODE_ADDR = 16'h020d;
  localparam logic [15:0] ADDR_FW_CLASS = 16'h020e;
  localparam logic [15:0] ADDR_FW_YEAR = 16'h020f;
  localparam logic [15:0] ADDR_CON_POWER = 16'h0211;
  localparam logic [15:0] ADDR_CON_RANGE = 16'h0213;
  localparam logic [15:0] ADDR_CON_TCOMP = 16'h0214;
  localparam logic [15:0] ADDR_IFT_SLOW = 16'h0215;
  localparam logic [15:0] ADDR_IFT_FAST = 16'h0216;
  localparam logic [15:0] ADDR_SPS = 16'h0223;
  localparam logic [15:0] ADDR_SERIAL_BASE = 16'h0250;
  localparam logic [15:0] ADDR_SERIAL_LAST = 16'h0257;
  // ==========================================================
  // Reset values and codes
  localparam logic [15:0] RST_NODE_ADDR = 16'h0001;
  localparam logic [15:0] RST_CON_RANGE = 16'h0004;
  localparam logic [15:0] RST_CON_TCOMP = 16'h0001;
  localparam logic [15:0] RST_IFT_SLOW = 16'h0023;
  localparam logic [15:0] RST_IFT_FAST = 16'h0012;
  localparam logic [15:0] RST_SPS = 16'h0005;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [15:0] CON_POWER_ON = 16'h0001;
  localparam logic [15:0] CON_RANGE_MIN = 16'h0001;
  localparam logic [15:0] CON_RANGE_MAX = 16'h0004;
  localparam logic [15:0] CON_TCOMP_MIN = 16'h0001;
  localparam logic [15:0] CON_TCOMP_MAX = 16'h0003;
  localparam logic [15:0] SPS_MIN = 16'h0005;
  localparam logic [15:0] SPS_MAX = 16'h0007;
  localparam logic [7:0] TRANSPARENT_ADDR = 8'h fa;
  localparam logic [7:0] EXC_BUSY = 8'h04;
  localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [3:0] OSR_BASE_EXP = 4'h8;
  // ==========================================================
  // Field positions
  localparam int FC_ADAPT_BIT = 0;
  localparam int FC_LPF_BIT = 1;
  localparam int FC_OSR_LSB = 2;
  localparam int FC_AVG_LSB = 5;
  localparam int AO_CURRENT_BIT = 0;
  localparam int AO_VOLTAGE_BIT = 1;
  localparam int AO_SRC_BIT = 4;
  localparam logic [15:0] FC_WR_MASK = 16'h007f;
  // ==========================================================
  // Timing
  localparam int CLK_HZ = 125_000_000;
  localparam int CON_POWERUP_MS = 3000;
  localparam int CON_POWERUP_CYC = CLK_HZ / 1000 * CON_POWERUP_MS;
  localparam int IFT_UNIT_US = 100;
  localparam int IFT_UNIT_CYC = CLK_HZ / 1_000_000 * IFT_UNIT_US;

  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } tcr_req_type;

  typedef struct packed {
    logic valid;
    logic [7:0] exc;
    logic [15:0] rdata;
  } tcr_rsp_type;

  typedef struct packed {
    logic adaptive_en;
    logic lowpass_en;
    logic [3:0] osr_exp;
    logic [3:0] avg_count;
    logic aout_src_first;
    logic con_powered;
    logic con_ready;
  } tcr_ctrl_type;
endpackage

// ==== verif/tcr_config_regs_bench.sv ====
`timescale 1ns/1ps
module tcr_config_regs_bench;
  import tcr_pkg::*;
  localparam logic [15:0] FW_CG = 16'h1234; // Arbitrary value
  logic i_core_clk = 1'b0;
  logic i_resetn = 1'b0;
  tcr_req_type cmd = '0;
  tcr_req_type req;
  logic [7:0] frame_addr = 8'h00;
  logic fast_baud = 1'b0;
  logic [1:0] aout_type = 2'b01;
  tcr_rsp_type rsp;
  tcr_rsp_type rsp2;
  logic [15:0] sps_code;
  tcr_ctrl_type ctrl;
  logic match;
  logic lowpass;
  logic [15:0] units;
  logic [31:0] cycles;
  logic sps_bad;
  int miscompares = 0;
  int cmp_count = 0;
  always #4 i_core_clk = ~i_core_clk;
  tcr_master_model u_tcr_master_model (.i_core_clk(i_core_clk),
    .i_resetn(i_resetn), .i_cmd(cmd), .o_req(req));
  tcr_config_regs #(.POWERUP_CYC(20), .FW_CLASS_GROUP(FW_CG))
    u_tcr_config_regs (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
    .i_req(req), .i_frame_addr(frame_addr), .i_fast_baud(fast_baud),
    .i_first_sensor_type(4'h2), .i_second_sensor_type(4'hf),
    .i_device_status(16'h0081), .i_aout_type(aout_type), .o_rsp(rsp),
    .o_addr_match(match), .o_ctrl(ctrl), .o_aout_lowpass(lowpass),
    .o_ift_units(units), .o_ift_cycles(cycles), .o_sps_invalid(sps_bad),
    .o_sps_code(sps_code));
  tcr_config_regs #(.POWERUP_CYC(20), .HAS_CAL_TYPE(1'b0),
    .SERIAL_WRITABLE(1'b0)) u_tcr_config_regs_lite (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_req(req),
    .i_frame_addr(frame_addr), .i_fast_baud(fast_baud),
    .i_first_sensor_type(4'h2), .i_second_sensor_type(4'hf),
    .i_device_status(16'h0081), .i_aout_type(aout_type), .o_rsp(rsp2),
    .o_addr_match(), .o_ctrl(), .o_aout_lowpass(), .o_ift_units(),
    .o_ift_cycles(), .o_sps_invalid(), .o_sps_code());
  // ==========================================================
  // Access tasks
  task automatic check(input string name, input logic [31:0] seen,
    input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic access(input logic w, input logic [15:0] a,
    input logic [15:0] d, input logic [7:0] exc, input logic [15:0] v);
    int n;
    n = 0;
    @(posedge i_core_clk);
    cmd <= '{1'b1, w, a, d};
    @(posedge i_core_clk);
    cmd.valid <= 1'b0;
    do begin
      @(negedge i_core_clk);
      n++;
    end while (rsp.valid !== 1'b1 && n < 4);
    check("rsp_valid", rsp.valid, 1'b1);
    check("rsp_exc", rsp.exc, exc);
    if (!w) check("rsp_rdata", rsp.rdata, v);
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] v);
    access(1'b0, a, 16'h0000, EXC_NONE, v);
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    access(1'b1, a, d, EXC_NONE, 16'h0000);
  endtask
  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Tests
  initial begin
    #200_000;
    miscompares++;
    final_report();
  end
  initial begin
    repeat (4) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    rd(ADDR_NODE_ADDR, 16'h0001);
    rd(ADDR_CON_RANGE, 16'h0004);
    rd(ADDR_CON_TCOMP, 16'h0001);
    rd(ADDR_IFT_SLOW, 16'h0023);
    rd(ADDR_IFT_FAST, 16'h0012);
    rd(ADDR_SENSOR_CAL, 16'h00f2);
    check("cal_absent", rsp2.rdata, 16'h0000);
    rd(ADDR_FW_CLASS, FW_CG);
    access(1'b0, 16'h0210, 16'h0000, EXC_ILLEGAL_ADDR, 16'h0000);
    wr(ADDR_FILTER_CTRL, 16'h0073);
    check("osr_exp", ctrl.osr_exp, OSR_BASE_EXP + 4'h4);
    check("avg", ctrl.avg_count, 4'h8);
    check("filters", {ctrl.adaptive_en, ctrl.lowpass_en}, 2'b11);
    check("aout_lp", lowpass, 1'b1);
    wr(ADDR_FILTER_CTRL, 16'hffff);
    rd(ADDR_FILTER_CTRL, 16'h007f);
    wr(ADDR_AOUT_CTRL, 16'hffff);
    rd(ADDR_AOUT_CTRL, 16'h0011);
    check("src_first", ctrl.aout_src_first, 1'b1);
    wr(ADDR_AOUT_CTRL, 16'h0000);
    check("src_calc", ctrl.aout_src_first, 1'b0);
    wr(ADDR_NODE_ADDR, 16'h0005);
    rd(ADDR_NODE_ADDR, 16'h0005);
    @(posedge i_core_clk);
    frame_addr <= 8'h06;
    @(negedge i_core_clk);
    check("match_other", match, 1'b0);
    @(posedge i_core_clk);
    frame_addr <= 8'h fa;
    @(negedge i_core_clk);
    check("match_transp", match, 1'b1);
    wr(ADDR_CON_RANGE, 16'h0003);
    wr(ADDR_CON_RANGE, 16'h0005);
    rd(ADDR_CON_RANGE, 16'h0003);
    wr(ADDR_CON_TCOMP, 16'h0002);
    wr(ADDR_CON_TCOMP, 16'h0000);
    rd(ADDR_CON_TCOMP, 16'h0002);
    wr(ADDR_IFT_SLOW, 16'h000a);
    check("ift_cyc", cycles, 32'd10 * IFT_UNIT_CYC);
    @(posedge i_core_clk);
    fast_baud <= 1'b1;
    repeat (3) @(negedge i_core_clk);
    check("ift_fast", units, 16'h0012);
    wr(ADDR_SPS, 16'h0009);
    check("sps_bad", sps_bad, 1'b1);
    wr(ADDR_SPS, 16'h0006);
    check("sps_ok", sps_bad, 1'b0);
    check("sps_code", sps_code, 16'h0006);
    wr(ADDR_SERIAL_LAST, 16'h4142);
    rd(ADDR_SERIAL_LAST, 16'h4142);
    check("serial_locked", rsp2.rdata, 16'h0000);
    wr(ADDR_CON_POWER, CON_POWER_ON);
    access(1'b0, ADDR_NODE_ADDR, 16'h0000, EXC_BUSY, 16'h0000);
    repeat (25) @(posedge i_core_clk);
    rd(ADDR_CON_POWER, CON_POWER_ON);
    check("con_ready", ctrl.con_ready, 1'b1);
    wr(ADDR_CON_POWER, 16'h0000);
    check("con_off", ctrl.con_powered, 1'b0);
    final_report();
  end
endmodule

// ==== verif/tcr_config_regs_checker.sv ====
`timescale 1ns/1ps
module tcr_config_regs_checker
  import tcr_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire tcr_pkg::tcr_req_type i_req,
  input wire logic [7:0] i_frame_addr,
  input wire tcr_pkg::tcr_rsp_type o_rsp,
  input wire logic o_addr_match,
  input wire tcr_pkg::tcr_ctrl_type o_ctrl,
  input wire logic o_aout_lowpass,
  input wire logic [15:0] o_ift_units,
  input wire logic [31:0] o_ift_cycles,
  input wire logic o_sps_invalid,
  input wire logic [15:0] o_sps_code
);
  // ==========================================================
  // Port relations
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  chk_rsp_one_cycle: assert property (i_req.valid |=> o_rsp.valid)
    else $error("response missing after request");
  chk_rsp_no_spurious: assert property (!i_req.valid |=> !o_rsp.valid)
    else $error("response without request");
  chk_busy_answer: assert property (i_req.valid && o_ctrl.con_powered
    && !o_ctrl.con_ready |=> o_rsp.exc == EXC_BUSY
    && o_rsp.rdata == 16'h0000)
    else $error("request during power-up not refused");
  chk_lowpass_both: assert property (o_aout_lowpass == o_ctrl.lowpass_en)
    else $error("analogue low-pass differs from filter setting");
  chk_ift_scale: assert property (
    o_ift_cycles == o_ift_units * 32'd12500)
    else $error("timeout cycles not units times 100 us");
  chk_sps_flag: assert property (o_sps_invalid ==
    (o_sps_code < 16'h0005 || o_sps_code > 16'h0007))
    else $error("sample rate validity flag wrong");
  chk_transparent_addr: assert property (
    i_frame_addr == 8'h fa |-> o_addr_match)
    else $error("transparent address not matched");
  chk_avg_power: assert property (o_ctrl.avg_count inside {4'h1, 4'h2, 4'h4,
    4'h8})
    else $error("averaging count not a power of two");
  chk_osr_floor: assert property (o_ctrl.osr_exp >= 4'h8
    && $stable(o_ctrl.osr_exp)
    || $past(i_req.valid) && $past(i_req.write))
    else $error("oversampling exponent wrong or changed without write");
endmodule
bind tcr_config_regs tcr_config_regs_checker u_tcr_config_regs_checker (
  .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_req(i_req),
  .i_frame_addr(i_frame_addr), .o_rsp(o_rsp), .o_addr_match(o_addr_match),
  .o_ctrl(o_ctrl), .o_aout_lowpass(o_aout_lowpass), .o_ift_units(o_ift_units),
  .o_ift_cycles(o_ift_cycles), .o_sps_invalid(o_sps_invalid),
  .o_sps_code(o_sps_code));

// ==== verif/tcr_master_model.sv ====
`timescale 1ns/1ps
module tcr_master_model (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire tcr_pkg::tcr_req_type i_cmd,
  output tcr_pkg::tcr_req_type o_req
);
  import tcr_pkg::*;
  // ==========================================================
  // Request launch
  // Requests leave on the clock edge for one cycle; nothing is held over
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_req <= '0;
    end else begin
      o_req <= i_cmd;
    end
  end
endmodule
